// ===== rtl/uts_consts.vh
`ifndef UTS_CONSTS_VH
`define UTS_CONSTS_VH

`define UTS_ADDR_W          8
`define UTS_OFF_STATUS      8'h00
`define UTS_OFF_BASE_MID    8'h04
`define UTS_OFF_BASE_TOP    8'h08
`define UTS_OFF_INT_STATUS  8'h0C
`define UTS_OFF_INT_MASK    8'h10
`define UTS_OFF_QUEUE_INFO  8'h14

`define UTS_EP_HI           7
`define UTS_EP_LO           4
`define UTS_DIR_BIT         3
`define UTS_BANK_BIT        2
`define UTS_REC_W           6

`define UTS_INT_TRN_BIT     3
`define UTS_INT_OVF_BIT     0
`define UTS_INT_W           4

`define UTS_QUEUE_DEPTH     4
`define UTS_BYTE_RST        8'h00
`define UTS_INT_RST         4'h0
`define UTS_TABLE_ALIGN_W   9

`endif

// ===== rtl/uts_rec_queue.v
`timescale 1ns/1ns
`include "uts_consts.vh"

// Small record queue; the head is always visible on head_data.
module uts_rec_queue #(
    parameter WIDTH = `UTS_REC_W,
    parameter DEPTH = `UTS_QUEUE_DEPTH,
    parameter AW    = 2
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    input  wire             pop,
    output wire [WIDTH-1:0] head_data,
    output wire             empty,
    output wire             full,
    output wire [AW:0]      count
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      cnt_q;
    wire             do_pop;
    wire             do_push;

    assign empty     = (cnt_q == {(AW+1){1'b0}});
    assign full      = (cnt_q == DEPTH[AW:0]);
    assign count     = cnt_q;
    assign head_data = mem[rd_q];
    assign do_pop    = pop && !empty;
    // A push into a full queue is allowed only when a pop frees a slot.
    assign do_push   = push && (!full || do_pop);

    // Storage has no reset: records are undefined until written.
    always @(posedge pclk) begin
        if (do_push) begin
            mem[wr_q] <= push_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // uts_rec_queue

// ===== rtl/uts_txn_status.v
`timescale 1ns/1ns
`include "uts_consts.vh"

// Operation
// - The status register shows in bits 7 to 4 the endpoint number of the oldest queued transfer, the queue head.
// - Status bit 3 is 1 for a transmit transfer and 0 for a receive transfer.
// - Status bit 2 is 1 for the odd descriptor bank and 0 for the even bank.
// - Completed records wait in a four-deep queue whose head the status register shows.
// - Status content is valid only while the transaction-done flag is set.
// - Clearing the transaction-done flag pops the head of the queue.
// - An 8-bit writable field supplies bits 23 to 16 of the table base address.
// - An 8-bit writable field supplies bits 31 to 24 of the table base address.
// - The table base is 512-byte aligned, so its lowest nine bits are zero.
// - Unimplemented bits read as zero.
module uts_txn_status (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        txn_done,
    input  wire [3:0]  txn_endpoint,
    input  wire        txn_is_tx,
    input  wire        txn_odd_bank,
    output reg  [31:0] table_base_addr,
    output reg         irq
);
    localparam ST_IDLE = 1'b0;
    localparam ST_ACC  = 1'b1;

    reg                      state_q;
    reg  [7:0]               table_base_mid_byte_q;
    reg  [7:0]               table_base_top_byte_q;
    reg  [`UTS_INT_W-1:0]    int_status_q;
    reg  [`UTS_INT_W-1:0]    int_mask_q;
    reg                      done_s1_q;
    reg                      done_s2_q;
    reg                      done_s3_q;
    reg  [`UTS_REC_W-1:0]    rec_s1_q;
    reg  [`UTS_REC_W-1:0]    rec_s2_q;
    reg  [31:0]              rdata_d;
    reg                      pslverr_d;
    wire [`UTS_REC_W-1:0]    head_rec;
    wire                     q_empty;
    wire                     q_full;
    wire [2:0]               q_count;
    wire                     acc;
    wire                     wr_acc;
    wire                     txn_event;
    wire                     trn_clear;
    wire                     overflow;
    wire [`UTS_INT_W-1:0]    int_set;
    wire [`UTS_INT_W-1:0]    int_clr;

    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `UTS_OFF_STATUS) || (a == `UTS_OFF_BASE_MID) ||
                        (a == `UTS_OFF_BASE_TOP) || (a == `UTS_OFF_INT_STATUS) ||
                        (a == `UTS_OFF_INT_MASK) || (a == `UTS_OFF_QUEUE_INFO);
        end
    endfunction

    // The access phase answers one cycle after penable rises, so pready rises in the
    // second cycle of penable; a zero-wait slave would need combinational outputs.
    assign acc    = psel && penable && (state_q == ST_ACC);
    assign wr_acc = acc && pwrite && is_mapped(paddr);

    // Transaction strobe and record come from the USB clock side; both are
    // synchronised, and the record is held stable around the strobe by its source.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            rec_s1_q  <= {`UTS_REC_W{1'b0}};
            rec_s2_q  <= {`UTS_REC_W{1'b0}};
        end else begin
            done_s1_q <= txn_done;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            rec_s1_q  <= {txn_endpoint, txn_is_tx, txn_odd_bank};
            rec_s2_q  <= rec_s1_q;
        end
    end

    assign txn_event = done_s2_q && !done_s3_q;

    // Write-one-to-clear of the transaction-done flag pops the queue head.
    assign trn_clear = wr_acc && (paddr == `UTS_OFF_INT_STATUS) &&
                       pwdata[`UTS_INT_TRN_BIT] && int_status_q[`UTS_INT_TRN_BIT];
    assign overflow  = txn_event && q_full && !trn_clear;

    uts_rec_queue #(
        .WIDTH (`UTS_REC_W),
        .DEPTH (`UTS_QUEUE_DEPTH),
        .AW    (2)
    ) u_queue (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (txn_event),
        .push_data (rec_s2_q),
        .pop       (trn_clear),
        .head_data (head_rec),
        .empty     (q_empty),
        .full      (q_full),
        .count     (q_count)
    );

    // The done flag is re-raised as long as records remain; a new event in the
    // clearing cycle wins over the clear.
    assign int_set = {1'b0, 1'b0, 1'b0, overflow};
    assign int_clr = (wr_acc && (paddr == `UTS_OFF_INT_STATUS)) ?
                     pwdata[`UTS_INT_W-1:0] : `UTS_INT_RST;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_q <= `UTS_INT_RST;
            int_mask_q   <= `UTS_INT_RST;
        end else begin
            int_status_q <= (int_status_q & ~int_clr) | int_set;
            int_status_q[`UTS_INT_TRN_BIT] <= txn_event ||
                (!q_empty && !(trn_clear && q_count == 3'h1));
            if (wr_acc && paddr == `UTS_OFF_INT_MASK) begin
                int_mask_q <= pwdata[`UTS_INT_W-1:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_base_mid_byte_q <= `UTS_BYTE_RST;
            table_base_top_byte_q <= `UTS_BYTE_RST;
        end else if (wr_acc) begin
            if (paddr == `UTS_OFF_BASE_MID) begin
                table_base_mid_byte_q <= pwdata[7:0];
            end
            if (paddr == `UTS_OFF_BASE_TOP) begin
                table_base_top_byte_q <= pwdata[7:0];
            end
        end
    end

    always @* begin
        rdata_d   = 32'h0000_0000;
        pslverr_d = !is_mapped(paddr);
        case (paddr)
            `UTS_OFF_STATUS: begin
                // Head record; stale when the done flag is low, as software knows.
                rdata_d[`UTS_EP_HI:`UTS_BANK_BIT] = head_rec;
            end
            `UTS_OFF_BASE_MID: begin
                rdata_d[7:0] = table_base_mid_byte_q;
            end
            `UTS_OFF_BASE_TOP: begin
                rdata_d[7:0] = table_base_top_byte_q;
            end
            `UTS_OFF_INT_STATUS: begin
                rdata_d[`UTS_INT_W-1:0] = int_status_q;
            end
            `UTS_OFF_INT_MASK: begin
                rdata_d[`UTS_INT_W-1:0] = int_mask_q;
            end
            `UTS_OFF_QUEUE_INFO: begin
                rdata_d[2:0] = q_count;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q         <= ST_IDLE;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            prdata          <= 32'h0000_0000;
            table_base_addr <= 32'h0000_0000;
            irq             <= 1'b0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (psel && penable) begin
                        state_q <= ST_ACC;
                        pready  <= 1'b1;
                        pslverr <= pslverr_d;
                        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
                    end
                end
                ST_ACC: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            table_base_addr <= {table_base_top_byte_q, table_base_mid_byte_q, 7'h00,
                                {`UTS_TABLE_ALIGN_W{1'b0}}};
            irq <= |(int_status_q & int_mask_q);
        end
    end

endmodule // uts_txn_status

// ===== sim/uts_txn_status_asserts.sv
`timescale 1ns/1ns
module uts_txn_status_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] table_base_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_done = pready && psel && penable && pwrite && !pslverr;
    wire rd_done = pready && psel && penable && !pwrite;
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    wait_state_a: assert property (psel && penable && !$past(penable) |=> pready)
        else $error("no answer after one wait state");
    // The byte register takes the write at the answer edge and the base output
    // follows one edge later, so the new value is seen two edges on.
    mid_write_a: assert property (wr_done && paddr == 8'h04 |-> ##2
        table_base_addr[23:16] == $past(pwdata[7:0], 2)) else $error("mid byte not written");
    top_write_a: assert property (wr_done && paddr == 8'h08 |-> ##2
        table_base_addr[31:24] == $past(pwdata[7:0], 2)) else $error("top byte not written");
    base_align_a: assert property (table_base_addr[15:0] == 16'h0000)
        else $error("table base low bits set");
    read_upper_a: assert property (rd_done |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    status_low_a: assert property (rd_done && paddr == 8'h00 |-> prdata[1:0] == 2'b00)
        else $error("status low bits set");
    reset_base_a: assert property ($rose(presetn) |-> table_base_addr == 32'h00000000)
        else $error("table base not cleared");
    cover property (wr_done && paddr == 8'h08);
    cover property (pready && pslverr);
    cover property (rd_done && paddr == 8'h00);
endmodule // uts_txn_status_asserts

bind uts_txn_status uts_txn_status_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .table_base_addr(table_base_addr));

// ===== sim/uts_usb_partner.sv
`timescale 1ns/1ns
module uts_usb_partner (
    input  wire logic       pclk,
    output logic            txn_done,
    output logic [3:0]      txn_endpoint,
    output logic            txn_is_tx,
    output logic            txn_odd_bank
);
    initial begin
        txn_done = 1'b0;
        {txn_endpoint, txn_is_tx, txn_odd_bank} = 6'h15;
    end
    // The record is only held around the done edge; outside it the lines show the
    // inverse, so a late sample inside the block cannot pass by luck.
    task send(input logic [3:0] ep, input logic tx, input logic odd);
        @(posedge pclk);
        {txn_endpoint, txn_is_tx, txn_odd_bank} <= {ep, tx, odd};
        repeat (3) @(posedge pclk);
        txn_done <= 1'b1;
        repeat (3) @(posedge pclk);
        {txn_endpoint, txn_is_tx, txn_odd_bank} <= ~{ep, tx, odd};
        txn_done <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule // uts_usb_partner

// ===== sim/tb_top.sv
`timescale 1ns/1ns
`include "uts_consts.vh"
module tb_top;
    typedef struct { logic [31:0] data; logic [31:0] mask; logic err; } uts_note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        txn_done, txn_is_tx, txn_odd_bank;
    logic [3:0]  txn_endpoint;
    logic [7:0]  paddr, mid_b;
    logic [31:0] pwdata, prdata, table_base_addr, lfsr;
    logic [5:0]  rec [4];
    uts_note_t   notes[$];
    uts_note_t   nt;
    int          n_fail, tests_run;

    uts_txn_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txn_done(txn_done), .txn_endpoint(txn_endpoint),
        .txn_is_tx(txn_is_tx), .txn_odd_bank(txn_odd_bank),
        .table_base_addr(table_base_addr), .irq(irq));
    uts_usb_partner i_usb (.pclk(pclk), .txn_done(txn_done), .txn_endpoint(txn_endpoint),
        .txn_is_tx(txn_is_tx), .txn_odd_bank(txn_odd_bank));

    always #50 pclk = ~pclk;

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // The expected answer is noted before the request goes out; the monitor pairs it.
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
             input logic [31:0] m, input logic er);
        notes.push_back('{e, m, er});
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                n_fail++;
                $display("wrong value answer expected none seen one");
            end else begin
                nt = notes.pop_front();
                check("prdata", prdata & nt.mask, nt.data);
                check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
            end
        end
    end

    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h00000000; lfsr = 32'h0000A5A3; n_fail = 0; tests_run = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("base", table_base_addr, 32'h00000000);
        apb(`UTS_OFF_BASE_MID, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
        apb(`UTS_OFF_BASE_TOP, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
        apb(`UTS_OFF_QUEUE_INFO, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
        repeat (4) begin
            lfsr = next_rand(lfsr);
            mid_b = lfsr[7:0];
            apb(`UTS_OFF_BASE_MID, 1'b1, lfsr, 32'h0, 32'h0, 1'b0);
            apb(`UTS_OFF_BASE_MID, 1'b0, 32'h0, {24'h0, mid_b}, 32'hFFFFFFFF, 1'b0);
            lfsr = next_rand(lfsr);
            apb(`UTS_OFF_BASE_TOP, 1'b1, lfsr, 32'h0, 32'h0, 1'b0);
            apb(`UTS_OFF_BASE_TOP, 1'b0, 32'h0, {24'h0, lfsr[7:0]}, 32'hFFFFFFFF, 1'b0);
            check("base", table_base_addr, {lfsr[7:0], mid_b, 16'h0000});
        end
        apb(8'h18, 1'b1, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
        apb(8'h18, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        for (int g = 0; g < 4; g++) begin
            apb(`UTS_OFF_INT_MASK, 1'b1, (g == 2) ? 32'h0 : 32'h8, 32'h0, 32'h0, 1'b0);
            apb(`UTS_OFF_INT_MASK, 1'b0, 32'h0, (g == 2) ? 32'h0 : 32'h8, 32'hFF, 1'b0);
            for (int i = 0; i < 4; i++) begin
                lfsr = next_rand(lfsr);
                rec[i] = {g[1:0], i[1:0], lfsr[1:0]};
                i_usb.send(rec[i][5:2], rec[i][1], rec[i][0]);
            end
            // A fifth record finds the queue full and is dropped.
            if (g == 3) i_usb.send(4'hF, 1'b1, 1'b1);
            repeat (2) @(posedge pclk);
            check("irq", {31'h0, irq}, (g == 2) ? 32'h0 : 32'h1);
            apb(`UTS_OFF_QUEUE_INFO, 1'b0, 32'h0, 32'h4, 32'hFFFFFFFF, 1'b0);
            apb(`UTS_OFF_INT_STATUS, 1'b0, 32'h0, (g == 3) ? 32'h9 : 32'h8, 32'hF, 1'b0);
            for (int i = 0; i < 4; i++) begin
                apb(`UTS_OFF_STATUS, 1'b0, 32'h0, {24'h0, rec[i], 2'b00}, 32'hFFFFFFFF,
                    1'b0);
                apb(`UTS_OFF_INT_STATUS, 1'b1, 32'h8, 32'h0, 32'h0, 1'b0);
            end
            apb(`UTS_OFF_INT_STATUS, 1'b1, 32'h1, 32'h0, 32'h0, 1'b0);
            apb(`UTS_OFF_INT_STATUS, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
            repeat (2) @(posedge pclk);
            check("irq", {31'h0, irq}, 32'h0);
        end
        give_verdict();
    end
endmodule // tb_top
